/* hdl/nvmpe_ctrl.sv */
// Data-page erase/write controller driven by CPU special function registers
`timescale 1ns/10ps
`include "nvmpe_defs.svh"
// Overview of operation
// RULE_01: Four 64-byte pages; erase clears whole page
// RULE_02: Page to erase derived from address register
// RULE_03: Erase stalls CPU until done, then resumes
// RULE_04: Control bit 7 requests page erase
// RULE_05: Control bit 6 programs data byte, CPU stalled
// RULE_06: Stall released once byte write finishes
// RULE_07: Page number equals address bits 7:6
// RULE_08: Write data register holds byte to program
// RULE_09: Data read back only via code-space read
// RULE_10: Address register is low location byte
// RULE_11: Control bits clear automatically on completion
// RULE_12: Software avoids both bits; erase before write
module nvmpe_ctrl #(
   parameter int PAGES = `NVMPE_PAGE_COUNT,
   parameter int PAGE_BYTES = `NVMPE_PAGE_BYTES,
   parameter int ERASE_CYC = `NVMPE_ERASE_CYC,
   parameter int WRITE_CYC = `NVMPE_WRITE_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_sfr_wr, // SFR write strobe, one cycle
   input wire logic i_sfr_rd, // SFR read strobe, one cycle
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata, // Registered SFR read data
   output logic o_sfr_hit, // Registered: last read addressed this block
   input wire logic i_code_rd, // Code-space read request, one cycle
   input wire logic [7:0] i_code_addr,
   output logic [7:0] o_code_rdata, // Valid one cycle after the request
   output logic o_code_valid,
   output logic o_cpu_stall // Holds program counter while busy
);
   // Derived sizes: array depth, in-page offset width and timer width
   localparam int DEPTH = PAGES * PAGE_BYTES;
   localparam int PW = $clog2(PAGE_BYTES);
   localparam int CW = $clog2(ERASE_CYC > WRITE_CYC ? ERASE_CYC + 1 : WRITE_CYC + 1);

   // Elaboration checks: the address split needs 256 bytes in whole pages
   if (DEPTH != 256 || PAGE_BYTES < 2) begin : g_bad_geometry
      $error("nvmpe_ctrl: geometry must span 256 bytes in whole pages");
   end
   // A zero time would leave the sequencer no cycle to finish in
   if (ERASE_CYC < 1 || WRITE_CYC < 1) begin : g_bad_timing
      $error("nvmpe_ctrl: operation times must be nonzero");
   end

   // Architectural registers and their next values
   nvmpe_pkg::nvmpe_state_t state, next_state; // Sequencer
   logic [7:0] nv_location_index, next_nv_location_index; // Address register
   logic [7:0] nv_write_byte_field, next_nv_write_byte_field; // Write data register
   logic page_erase_request, next_page_erase_request; // Control bit 7
   logic byte_write_request, next_byte_write_request; // Control bit 6
   logic [CW-1:0] timer, next_timer; // Operation time left
   logic [PW-1:0] erase_ofs, next_erase_ofs; // Byte within page being erased
   // Next values of the registered outputs
   logic [7:0] next_sfr_rdata; // Read answer
   logic next_sfr_hit; // Read addressed this block
   logic next_code_valid; // Code read answer strobe
   logic next_cpu_stall; // Core hold
   // Array port, shared by the erase walk and the byte write
   logic mem_we; // Array write strobe
   logic [7:0] mem_waddr; // Array write address
   logic [7:0] mem_wdata; // Array write data
   logic [7:0] mem_rdata; // Registered array read data

   // The array has no reset: its content outlives a core reset, as a
   // nonvolatile store should, and reads unknown until first written
   nvmpe_mem #(
      .DEPTH(256),
      .AW(8)
   ) u_mem (
      .i_sys_clk(i_sys_clk),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(mem_wdata),
      .i_raddr(i_code_addr),
      .o_rdata(mem_rdata)
   );

   // Output data comes straight from the array's read register
   // Code reads are not refused while busy; the byte being written may
   // still show its old value until the last stall cycle
   assign o_code_rdata = mem_rdata; // RULE_09

   // Next-state logic for registers and the erase/write sequencer
   // Writes are ignored while busy; the stall keeps the core from sending any
   always_comb begin
      // Hold every register unless an event below changes it
      next_state = state;
      next_nv_location_index = nv_location_index;
      next_nv_write_byte_field = nv_write_byte_field;
      next_page_erase_request = page_erase_request;
      next_byte_write_request = byte_write_request;
      next_timer = timer;
      next_erase_ofs = erase_ofs;
      // Read answers stand for one cycle only
      next_sfr_rdata = `NVMPE_RST_BYTE;
      next_sfr_hit = 1'b0;
      next_code_valid = i_code_rd;
      // Array defaults point at the byte write target
      mem_we = 1'b0;
      mem_waddr = nv_location_index;
      mem_wdata = nv_write_byte_field;
      // SFR writes; the core is stalled while busy so none arrive mid-operation
      if (i_sfr_wr && state == nvmpe_pkg::NVMPE_IDLE) begin
         unique case (i_sfr_addr)
            `NVMPE_ADDR_INDEX: begin
               // Any byte of a page selects that page for erase
               next_nv_location_index = i_sfr_wdata; // RULE_10
            end
            `NVMPE_ADDR_WDATA: begin
               // Held until the next write; the byte is not read back here
               next_nv_write_byte_field = i_sfr_wdata; // RULE_08
            end
            `NVMPE_ADDR_CONTROL: begin
               // The low six bits are reserved and ignored
               // Erase wins if software sets both, keeping the page consistent
               if (i_sfr_wdata[`NVMPE_BIT_ERASE]) begin
                  next_page_erase_request = 1'b1; // RULE_04
                  next_state = nvmpe_pkg::NVMPE_ERASE; // RULE_03
                  next_timer = CW'(ERASE_CYC - 1);
                  next_erase_ofs = '0;
               end else if (i_sfr_wdata[`NVMPE_BIT_WRITE]) begin
                  next_byte_write_request = 1'b1; // RULE_05
                  next_state = nvmpe_pkg::NVMPE_WRITE;
                  next_timer = CW'(WRITE_CYC - 1);
               end
            end
            default: begin
               // Other SFR addresses belong to other blocks
            end
         endcase
      end
      // SFR reads; the write data register is write-only and reads as zero
      // Unmapped addresses leave hit low so another block can answer
      if (i_sfr_rd) begin
         if (i_sfr_addr == `NVMPE_ADDR_INDEX) begin
            next_sfr_rdata = nv_location_index;
            next_sfr_hit = 1'b1;
         end else if (i_sfr_addr == `NVMPE_ADDR_CONTROL) begin
            next_sfr_rdata = {page_erase_request, byte_write_request, 6'h00};
            next_sfr_hit = 1'b1;
         end else if (i_sfr_addr == `NVMPE_ADDR_WDATA) begin
            next_sfr_hit = 1'b1; // RULE_09
         end
      end
      // Sequencer
      unique case (state)
         nvmpe_pkg::NVMPE_IDLE: begin
            // Waiting for a control write
         end
         nvmpe_pkg::NVMPE_ERASE: begin
            // One byte of the page per cycle until every byte is blank
            // Page bits come from the address register, offset from the walk
            mem_waddr = {nv_location_index[7:PW], erase_ofs}; // RULE_02 RULE_07 RULE_01
            mem_wdata = `NVMPE_ERASED_BYTE;
            // The last byte waits for the timer so the page is blank on exit
            mem_we = (erase_ofs != '1) || (timer == '0);
            if (erase_ofs != '1) begin
               next_erase_ofs = erase_ofs + 1'b1;
            end
            // Finish only once both the walk and the timer are done
            if (timer == '0 && erase_ofs == '1) begin
               next_page_erase_request = 1'b0; // RULE_11
               next_state = nvmpe_pkg::NVMPE_IDLE; // RULE_03
            end else if (timer != '0) begin
               next_timer = timer - 1'b1;
            end
         end
         nvmpe_pkg::NVMPE_WRITE: begin
            // The byte lands in the last cycle of the stall, so a read
            // issued after the stall always sees it
            if (timer == '0) begin
               mem_we = 1'b1; // RULE_05
               next_byte_write_request = 1'b0; // RULE_11
               next_state = nvmpe_pkg::NVMPE_IDLE; // RULE_06
            end else begin
               next_timer = timer - 1'b1;
            end
         end
      endcase
      // Stall follows the next state so it rises on the control write edge
      // and falls on the edge that returns the sequencer to idle
      next_cpu_stall = (next_state != nvmpe_pkg::NVMPE_IDLE); // RULE_03 RULE_06
   end

   // Register stage
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         // Idle with nothing pending; the array itself is untouched
         state <= nvmpe_pkg::NVMPE_IDLE;
         nv_location_index <= `NVMPE_RST_BYTE;
         nv_write_byte_field <= `NVMPE_RST_BYTE;
         page_erase_request <= 1'b0;
         byte_write_request <= 1'b0;
         timer <= '0;
         erase_ofs <= '0;
         o_sfr_rdata <= `NVMPE_RST_BYTE;
         o_sfr_hit <= 1'b0;
         o_code_valid <= 1'b0;
         o_cpu_stall <= 1'b0;
      end else begin
         // Take the next values computed above
         state <= next_state;
         nv_location_index <= next_nv_location_index;
         nv_write_byte_field <= next_nv_write_byte_field;
         page_erase_request <= next_page_erase_request;
         byte_write_request <= next_byte_write_request;
         timer <= next_timer;
         erase_ofs <= next_erase_ofs;
         o_sfr_rdata <= next_sfr_rdata;
         o_sfr_hit <= next_sfr_hit;
         o_code_valid <= next_code_valid;
         o_cpu_stall <= next_cpu_stall;
      end
   end
endmodule // nvmpe_ctrl

/* hdl/nvmpe_defs.svh */
// Offsets, field positions, reset values and timing counts for the data-page erase/write block
`ifndef NVMPE_DEFS_SVH
`define NVMPE_DEFS_SVH
// Special function register addresses
`define NVMPE_ADDR_INDEX 8'hC7
`define NVMPE_ADDR_CONTROL 8'hCE
`define NVMPE_ADDR_WDATA 8'hCF
// Control register fields
`define NVMPE_BIT_ERASE 7
`define NVMPE_BIT_WRITE 6
// Reset values
`define NVMPE_RST_BYTE 8'h00
`define NVMPE_ERASED_BYTE 8'hFF
// Array geometry
`define NVMPE_PAGE_COUNT 4
`define NVMPE_PAGE_BYTES 64
// Operation times in microseconds and derived cycle counts at 25 MHz
`define NVMPE_CLK_MHZ 25
`define NVMPE_ERASE_US 20
`define NVMPE_WRITE_US 2
`define NVMPE_ERASE_CYC (`NVMPE_ERASE_US * `NVMPE_CLK_MHZ)
`define NVMPE_WRITE_CYC (`NVMPE_WRITE_US * `NVMPE_CLK_MHZ)
`endif

/* hdl/nvmpe_pkg.sv */
// Types shared by the data-page erase/write block
package nvmpe_pkg;
   // Sequencer states
   typedef enum logic [1:0] {
      NVMPE_IDLE,
      NVMPE_ERASE,
      NVMPE_WRITE
   } nvmpe_state_t;
endpackage

/* hdl/nvmpe_mem.sv */
// Nonvolatile data array storage with registered read port
`timescale 1ns/10ps
module nvmpe_mem #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_we, // Store one byte
   input wire logic [AW-1:0] i_waddr,
   input wire logic [7:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [7:0] o_rdata // Registered read data
);
   logic [7:0] mem [DEPTH]; // Storage; erased content comes from the controller
   // Elaboration check: every address must name exactly one stored byte
   if (DEPTH != (1 << AW)) begin : g_bad_depth
      $error("nvmpe_mem: DEPTH must equal 2**AW");
   end
   // Write and registered read
   always_ff @(posedge i_sys_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule // nvmpe_mem

/* dv/nvmpe_ctrl_props.sv */
// Port checker for the data-page erase/write controller
`timescale 1ns/10ps
`include "nvmpe_defs.svh"
module nvmpe_ctrl_props #(
   parameter int ERASE_CYC = `NVMPE_ERASE_CYC,
   parameter int WRITE_CYC = `NVMPE_WRITE_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic o_sfr_hit,
   input wire logic i_code_rd,
   input wire logic [7:0] i_code_addr,
   input wire logic [7:0] o_code_rdata,
   input wire logic o_code_valid,
   input wire logic o_cpu_stall
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   logic [15:0] cnt; // Cycles the stall has stood
   logic ers; // Running operation is an erase
   logic go; // Control write taken while idle
   assign go = i_sfr_wr && i_sfr_addr == `NVMPE_ADDR_CONTROL && !o_cpu_stall;
   // A counter, since a repetition would unroll hundreds of cycles
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt <= 16'h0000;
         ers <= 1'b0;
      end else begin
         cnt <= o_cpu_stall ? cnt + 16'h0001 : 16'h0000;
         ers <= go ? i_sfr_wdata[7] : ers;
      end
   end
   AST_ERASE_GO: assert property (go && i_sfr_wdata[7] |=> o_cpu_stall)
      else $error("erase did not stall");
   AST_WRITE_GO: assert property (go && i_sfr_wdata[7:6] == 2'b01 |=> o_cpu_stall)
      else $error("write did not stall");
   AST_NO_OP: assert property (go && i_sfr_wdata[7:6] == 2'b00 |=> !o_cpu_stall)
      else $error("stall with no request");
   AST_STALL_LEN: assert property ($fell(o_cpu_stall) |->
      cnt == 16'(ers ? ERASE_CYC : WRITE_CYC)) else $error("stall length wrong");
   AST_CLEAR: assert property (i_sfr_rd && i_sfr_addr == `NVMPE_ADDR_CONTROL &&
      !o_cpu_stall |=> o_sfr_hit && o_sfr_rdata[7:6] == 2'b00) else $error("bits not cleared");
   AST_DATA_HIDDEN: assert property (i_sfr_rd && i_sfr_addr == `NVMPE_ADDR_WDATA
      |=> o_sfr_hit && o_sfr_rdata == 8'h00) else $error("write data readable");
   AST_UNMAPPED: assert property (i_sfr_rd && i_sfr_addr == 8'hD0
      |=> !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("unmapped read hit");
   AST_CODE_VALID: assert property (i_code_rd |=> o_code_valid)
      else $error("code read gave no answer");
   cover property ($fell(o_cpu_stall) && ers);
   cover property ($fell(o_cpu_stall) && !ers);
   cover property (o_code_valid);
endmodule // nvmpe_ctrl_props
bind nvmpe_ctrl nvmpe_ctrl_props #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC)) props_u (
   .i_sys_clk, .i_reset_n, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata,
   .o_sfr_hit, .i_code_rd, .i_code_addr, .o_code_rdata, .o_code_valid, .o_cpu_stall);

/* dv/nvmpe_cpu.sv */
// Behavioural CPU core issuing register writes, register reads and code reads
`timescale 1ns/10ps
module nvmpe_cpu (
   input wire logic i_sys_clk,
   input wire logic i_stall,
   input wire logic [7:0] i_rdata,
   input wire logic i_hit,
   input wire logic [7:0] i_cdata,
   input wire logic i_cvalid,
   output logic o_wr,
   output logic o_rd,
   output logic o_crd,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   initial begin
      {o_wr, o_rd, o_crd, o_addr, o_wdata} = 19'h0_0000;
   end
   // Write one register, then sit halted on it while the block is busy
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output int n);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_sys_clk);
      o_wr <= 1'b0;
      o_addr <= ~a; // Released lines never keep the last value
      o_wdata <= ~d;
      n = 0;
      @(posedge i_sys_clk);
      while (i_stall === 1'b1 && n < 2000) begin
         @(posedge i_sys_clk);
         n++;
      end
   endtask
   // Register read (code low) or code-space read; answer one cycle on
   task automatic rd(input logic [7:0] a, input logic code, output logic [8:0] r);
      o_crd <= code;
      o_rd <= !code;
      o_addr <= a;
      @(posedge i_sys_clk);
      {o_crd, o_rd} <= 2'h0;
      o_addr <= ~a;
      @(posedge i_sys_clk);
      r = code ? {i_cvalid, i_cdata} : {i_hit, i_rdata};
   endtask
endmodule // nvmpe_cpu

/* dv/nvm_data_page_erase_write_test.sv */
// Self-checking bench for the data-page erase/write controller
`timescale 1ns/10ps
`include "nvmpe_defs.svh"
module nvm_data_page_erase_write_test;
   localparam int ERS = 70; // Short erase, still long enough for a page
   localparam int WRS = 3;
   logic i_sys_clk, i_reset_n, i_sfr_wr, i_sfr_rd, o_sfr_hit, i_code_rd, o_code_valid, o_cpu_stall;
   logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, o_code_rdata;
   logic [7:0] wa [4] = '{8'h3F, 8'h40, 8'h7F, 8'h80}; // Both edges of page 1 and the adjoining bytes of pages 0 and 2
   logic [8:0] r;
   int miscompares = 0, n_compared = 0, n;
   nvmpe_ctrl #(.ERASE_CYC(ERS), .WRITE_CYC(WRS)) dut_u (.i_sys_clk, .i_reset_n, .i_sfr_wr,
      .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata, .o_sfr_hit, .i_code_rd,
      .i_code_addr(i_sfr_addr), .o_code_rdata, .o_code_valid, .o_cpu_stall);
   nvmpe_cpu cpu_u (.i_sys_clk, .i_stall(o_cpu_stall), .i_rdata(o_sfr_rdata), .i_hit(o_sfr_hit),
      .i_cdata(o_code_rdata), .i_cvalid(o_code_valid), .o_wr(i_sfr_wr), .o_rd(i_sfr_rd),
      .o_crd(i_code_rd), .o_addr(i_sfr_addr), .o_wdata(i_sfr_wdata));
   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end
   task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Erase every page from an index inside it, write page edges, erase page 1 again
   initial begin
      i_reset_n = 1'b0;
      repeat (3) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      @(posedge i_sys_clk);
      cpu_u.wr(`NVMPE_ADDR_INDEX, 8'h45, n);
      cpu_u.rd(`NVMPE_ADDR_INDEX, 1'b0, r);
      chk("index", 9'h145, r);
      for (int p = 0; p < 4; p++) begin
         cpu_u.wr(`NVMPE_ADDR_INDEX, 8'(p * 64 + p * 21), n);
         cpu_u.wr(`NVMPE_ADDR_CONTROL, 8'h80, n);
         chk("erase cycles", 9'(ERS), 9'(n));
         cpu_u.rd(8'(p * 64), 1'b1, r);
         chk("page first", 9'h1FF, r);
         cpu_u.rd(8'(p * 64 + 63), 1'b1, r);
         chk("page last", 9'h1FF, r);
      end
      foreach (wa[i]) begin
         cpu_u.wr(`NVMPE_ADDR_INDEX, wa[i], n);
         cpu_u.wr(`NVMPE_ADDR_WDATA, wa[i] ^ 8'hA5, n);
         cpu_u.wr(`NVMPE_ADDR_CONTROL, 8'h40, n);
         chk("write cycles", 9'(WRS), 9'(n));
         cpu_u.rd(`NVMPE_ADDR_CONTROL, 1'b0, r);
         chk("control", 9'h100, r);
         cpu_u.rd(wa[i], 1'b1, r);
         chk("byte", {1'b1, wa[i] ^ 8'hA5}, r);
      end
      cpu_u.wr(`NVMPE_ADDR_INDEX, 8'h7F, n);
      cpu_u.wr(`NVMPE_ADDR_CONTROL, 8'h80, n);
      foreach (wa[i]) begin
         cpu_u.rd(wa[i], 1'b1, r);
         chk("kept", (wa[i][7:6] == 2'b01) ? 9'h1FF : {1'b1, wa[i] ^ 8'hA5}, r);
      end
      cpu_u.rd(`NVMPE_ADDR_WDATA, 1'b0, r);
      chk("data reg", 9'h100, r);
      cpu_u.wr(`NVMPE_ADDR_CONTROL, 8'h00, n);
      chk("no op", 9'h000, 9'(n));
      cpu_u.rd(8'hD0, 1'b0, r);
      chk("unmapped", 9'h000, r);
      wrap_up();
   end
   // Guard against a stall that never ends
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      miscompares++;
      wrap_up();
   end
endmodule // nvm_data_page_erase_write_test
